// *** test/routed_spi_master_tb.sv ***
// self-checking bench for the routed spi master
`timescale 1ns/100ps
module routed_spi_master_tb;
	logic ref_clk = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0, flag_set = 0, flag_clr = 0;
	logic sel_n = 1, pend = 0, serial_done_flag, p1_sck_o, p1_mosi_o, p1_drive_oe_n;
	logic radio_sck, radio_mosi, miso;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, tx = 0, rx, d;
	logic [7:0] exp_q[$];
	int n_errors = 0, total_checks = 0, n, h;
	always #2.5 ref_clk = ~ref_clk;
	rsm_top dut (.ref_clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
		.flag_set, .flag_clr, .serial_done_flag, .p1_sck_o, .p1_mosi_o, .p1_drive_oe_n,
		.p1_miso_i(miso), .radio_sck, .radio_mosi, .radio_miso(miso));
	rsm_slave peer (.sck(p1_sck_o | radio_sck), .mosi(p1_mosi_o | radio_mosi), .sel_n,
		.tx, .miso, .rx);
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task wr(input logic [7:0] a, v);
		@(posedge ref_clk) #1 sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1;
		@(posedge ref_clk) #1 sfr_wr = 0;
	endtask
	task rd(input logic [7:0] a, v);
		@(posedge ref_clk) #1 sfr_addr = a;
		sfr_rd = 1;
		exp_q.push_back(v);
		@(posedge ref_clk) #1 sfr_rd = 0;
	endtask
	always @(posedge ref_clk) pend <= sfr_rd;
	always @(negedge ref_clk) if (pend) chk("rdata", sfr_rdata, exp_q.pop_front());
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(85));
		repeat (12) @(posedge ref_clk);
		#1 rstn = 1;
		rd(8'hb2, 8'h00);
		rd(8'hb5, 8'h00);
		wr(8'hb3, 8'hff);
		wr(8'hb4, 8'hff);
		rd(8'hb3, 8'h03);
		rd(8'hb4, 8'h0f);
		wr(8'hb3, 8'h00);
		wr(8'hb2, 8'h5a);
		n = 0;
		repeat (40) @(posedge ref_clk) #1 n += p1_sck_o | radio_sck | serial_done_flag;
		chk("idle", n[15:0], 16'h0);
		for (int c = 0; c < 8; c++) begin
			d = $urandom;
			tx = $urandom;
			wr(8'hb3, {6'h0, ~c[0], c[0]});
			wr(8'hb4, 8'(c));
			sel_n = 0;
			wr(8'hb2, d);
			wr(8'hb2, ~d);
			h = c < 2 ? 1 : c > 6 ? 32 : 1 << (c - 1);
			n = 3;
			while (!serial_done_flag && n < 3000) @(posedge ref_clk) #1 n++;
			chk("cycles", n[15:0], 16'(1 + 16 * h));
			if (n >= 3000) finish_test;
			sel_n = 1;
			rd(8'hb2, tx);
			chk("peer", rx, d);
			chk("sticky", serial_done_flag, 16'h1);
			chk("oe_n", p1_drive_oe_n, 16'(!c[0]));
			@(posedge ref_clk) #1 flag_clr = 1;
			@(posedge ref_clk) #1 flag_clr = 0;
			chk("clear", serial_done_flag, 16'h0);
		end
		@(posedge ref_clk) #1 flag_set = 1;
		@(posedge ref_clk) #1 flag_set = 0;
		chk("set", serial_done_flag, 16'h1);
		finish_test;
	end
endmodule

// *** test/rsm_props.sv ***
// port assertions for the routed spi master
`timescale 1ns/100ps
module rsm_props (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic       flag_set,
	input wire logic       flag_clr,
	input wire logic       serial_done_flag,
	input wire logic       p1_sck_o,
	input wire logic       p1_mosi_o,
	input wire logic       p1_drive_oe_n,
	input wire logic       radio_sck,
	input wire logic       radio_mosi
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	sequence cfg_rd;
		sfr_rd && (sfr_addr == 8'hb3 || sfr_addr == 8'hb4);
	endsequence
	p1_quiet_a: assert property (p1_drive_oe_n |-> !p1_sck_o && !p1_mosi_o)
		else $error("port pins active while undriven");
	one_route_a: assert property (!p1_drive_oe_n |-> !radio_sck && !radio_mosi)
		else $error("both routes active");
	flag_set_a: assert property (flag_set |=> serial_done_flag)
		else $error("flag not set by software");
	flag_hold_a: assert property (serial_done_flag && !flag_clr |=> serial_done_flag)
		else $error("flag dropped without clear");
	cfg_upper_a: assert property (cfg_rd |=> sfr_rdata[7:4] == 4'h0)
		else $error("config upper bits not zero");
	unmapped_a: assert property ((sfr_rd && (sfr_addr < 8'hb2 || sfr_addr > 8'hb4))
		|=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");
	mosi_low_a: assert property (!p1_drive_oe_n && $changed(p1_mosi_o) |-> !p1_sck_o)
		else $error("mosi changed with clock high");
endmodule
bind rsm_top rsm_props u_props (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(sfr_addr),
	.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .flag_set(flag_set), .flag_clr(flag_clr),
	.serial_done_flag(serial_done_flag), .p1_sck_o(p1_sck_o), .p1_mosi_o(p1_mosi_o),
	.p1_drive_oe_n(p1_drive_oe_n), .radio_sck(radio_sck), .radio_mosi(radio_mosi));

// *** test/rsm_slave.sv ***
// mode 0 slave standing in for the radio or the boot memory
`timescale 1ns/100ps
module rsm_slave (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_n, // any port zero gpio may drive this select
	input  wire logic [7:0] tx,
	output logic            miso,
	output logic      [7:0] rx
);
	logic [7:0] sh;
	// a deselected slave must not look like it still holds its bit
	assign miso = sel_n ? ~sh[7] : sh[7];
	always @(negedge sel_n) sh = tx;
	always @(posedge sck) rx <= {rx[6:0], mosi};
	always @(negedge sck) sh <= sh << 1;
endmodule

// *** verilog/rsm_pkg.sv ***
// constants shared by the routed spi master
package rsm_pkg;
	localparam logic [7:0] ADDR_SHIFT_BYTE   = 8'hb2;
	localparam logic [7:0] ADDR_ROUTE_SELECT = 8'hb3;
	localparam logic [7:0] ADDR_RATE_DIVIDER = 8'hb4;

	localparam int ROUTE_W = 2;
	localparam int RATE_W  = 4;
	localparam int BYTE_W  = 8;
	localparam int HALF_W  = 5;

	localparam logic [BYTE_W-1:0]  RESET_SHIFT_BYTE   = 8'h00;
	localparam logic [ROUTE_W-1:0] RESET_ROUTE_SELECT = 2'h0;
	localparam logic [RATE_W-1:0]  RESET_RATE_DIVIDER = 4'h0;

	localparam logic [ROUTE_W-1:0] ROUTE_OFF   = 2'h0;
	localparam logic [ROUTE_W-1:0] ROUTE_PORT1 = 2'h1;
	localparam logic [ROUTE_W-1:0] ROUTE_RADIO = 2'h2;

	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic {RSM_IDLE, RSM_SHIFT} rsm_state_t;
endpackage

// *** verilog/rsm_rate_gen.sv ***
// serial clock half-period tick generator
`timescale 1ns/100ps
module rsm_rate_gen (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       run,
	input  wire logic [3:0] rate_code,
	output logic            tick
);
	// cycles per half period minus one; sck period is the divide factor
	function automatic logic [rsm_pkg::HALF_W-1:0] half_last(input logic [3:0] code);
		unique case (code)
			4'h0, 4'h1: half_last = 5'h00;
			4'h2:       half_last = 5'h01;
			4'h3:       half_last = 5'h03;
			4'h4:       half_last = 5'h07;
			4'h5:       half_last = 5'h0f;
			default:    half_last = 5'h1f;
		endcase
	endfunction

	logic [rsm_pkg::HALF_W-1:0] cnt_q;
	logic [rsm_pkg::HALF_W-1:0] cnt_d;
	wire                        at_end = (cnt_q == half_last(rate_code));

	assign tick  = run && at_end;
	assign cnt_d = (!run || at_end) ? 5'h00 : cnt_q + 5'h01;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 5'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// *** verilog/rsm_top.sv ***
// routed spi master: special function registers, shifter and pin steering
//
// Function
// - master only, one transfer buffer, data writes while busy are dropped.
// - bus lines steered to port one low pins or to internal radio/converter.
// - route 00 idle without clock, 01 port one, 10 radio.
// - no slave select output is produced by this block.
// - sck is cpu clock over 2,2,4,8,16,32 then 64 for higher codes.
// - ready flag sets after eight bits, sticky until software clears; software may set.
`timescale 1ns/100ps
module rsm_top (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	input  wire logic       flag_set,
	input  wire logic       flag_clr,
	output logic            serial_done_flag,
	output logic            p1_sck_o,
	output logic            p1_mosi_o,
	output logic            p1_drive_oe_n,
	input  wire logic       p1_miso_i,
	output logic            radio_sck,
	output logic            radio_mosi,
	input  wire logic       radio_miso
);
	////////////////////////////////////////////////////////////////////////////////
	// registers

	logic [rsm_pkg::BYTE_W-1:0]  shift_q;
	logic [rsm_pkg::BYTE_W-1:0]  shift_d;
	logic [rsm_pkg::ROUTE_W-1:0] route_q;
	logic [rsm_pkg::RATE_W-1:0]  rate_q;
	logic [2:0]                  bit_q;
	logic [2:0]                  bit_d;
	logic                        sck_q;
	logic                        sck_d;
	logic                        rx_bit_q;
	logic                        rx_bit_d;
	logic                        flag_d;
	logic                        done;
	logic                        tick;
	rsm_pkg::rsm_state_t         state_q;
	rsm_pkg::rsm_state_t         state_d;

	wire sel_data  = (sfr_addr == rsm_pkg::ADDR_SHIFT_BYTE);
	wire sel_route = (sfr_addr == rsm_pkg::ADDR_ROUTE_SELECT);
	wire sel_rate  = (sfr_addr == rsm_pkg::ADDR_RATE_DIVIDER);
	wire busy      = (state_q == rsm_pkg::RSM_SHIFT);
	wire route_p1  = (route_q == rsm_pkg::ROUTE_PORT1);
	wire route_rf  = (route_q == rsm_pkg::ROUTE_RADIO);
	// route 00 and the unused code 11 connect nothing, so no clock runs
	wire route_on  = route_p1 || route_rf;
	// only one byte is held; a write during an exchange would corrupt it
	wire start     = sfr_wr && sel_data && !busy && route_on;
	wire miso_mux  = route_p1 ? p1_miso_i : (route_rf ? radio_miso : 1'b0);
	wire wr_data   = sfr_wr && sel_data;
	// mode 0: sample on the rising half, shift on the falling half
	wire sck_rise  = tick && !sck_q;
	wire sck_fall  = tick && sck_q;
	wire last_fall = sck_fall && (bit_q == rsm_pkg::LAST_BIT);

	////////////////////////////////////////////////////////////////////////////////
	// register bus read decode

	// unmapped addresses read as zero so stray reads never see stale data
	function automatic logic [7:0] read_word(
		input logic [7:0]                  addr,
		input logic [rsm_pkg::BYTE_W-1:0]  data,
		input logic [rsm_pkg::ROUTE_W-1:0] route,
		input logic [rsm_pkg::RATE_W-1:0]  rate
	);
		unique case (addr)
			rsm_pkg::ADDR_SHIFT_BYTE:   read_word = data;
			rsm_pkg::ADDR_ROUTE_SELECT: read_word = {6'h00, route};
			rsm_pkg::ADDR_RATE_DIVIDER: read_word = {4'h0, rate};
			default:                    read_word = 8'h00;
		endcase
	endfunction

	wire [7:0] rd_mux = read_word(sfr_addr, shift_q, route_q, rate_q);

	////////////////////////////////////////////////////////////////////////////////
	// clock divider

	rsm_rate_gen u_rate (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.run       (busy),
		.rate_code (rate_q),
		.tick      (tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// shifter, mode 0: sample on rising edge, shift on falling edge

	always_comb begin
		state_d  = state_q;
		shift_d  = shift_q;
		bit_d    = bit_q;
		sck_d    = sck_q;
		rx_bit_d = rx_bit_q;
		done     = 1'b0;
		unique case (state_q)
			rsm_pkg::RSM_IDLE: begin
				if (start) begin
					state_d = rsm_pkg::RSM_SHIFT;
					shift_d = sfr_wdata;
					bit_d   = 3'h0;
					sck_d   = 1'b0;
				end else if (wr_data) begin
					// route off: the byte is kept but nothing is clocked out
					shift_d = sfr_wdata;
				end
			end
			rsm_pkg::RSM_SHIFT: begin
				// data writes are ignored here, the single buffer is in use
				if (sck_rise) begin
					sck_d    = 1'b1;
					rx_bit_d = miso_mux;
				end else if (sck_fall) begin
					sck_d   = 1'b0;
					shift_d = {shift_q[6:0], rx_bit_q};
					bit_d   = bit_q + 3'h1;
				end
				if (last_fall) begin
					state_d = rsm_pkg::RSM_IDLE;
					done    = 1'b1;
				end
			end
		endcase
	end

	// hardware and software set win over a clear in the same cycle
	assign flag_d = done || flag_set || (serial_done_flag && !flag_clr);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q  <= rsm_pkg::RSM_IDLE;
			shift_q  <= rsm_pkg::RESET_SHIFT_BYTE;
			bit_q    <= 3'h0;
			sck_q    <= 1'b0;
			rx_bit_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			shift_q  <= shift_d;
			bit_q    <= bit_d;
			sck_q    <= sck_d;
			rx_bit_q <= rx_bit_d;
		end
	end

	// the route may be rewritten mid-exchange; the pins follow at once
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			route_q <= rsm_pkg::RESET_ROUTE_SELECT;
		end else if (sfr_wr && sel_route) begin
			route_q <= sfr_wdata[1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rate_q <= rsm_pkg::RESET_RATE_DIVIDER;
		end else if (sfr_wr && sel_rate) begin
			rate_q <= sfr_wdata[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data and ready flag

	wire [7:0] rdata_d = sfr_rd ? rd_mux : sfr_rdata;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata        <= 8'h00;
			serial_done_flag <= 1'b0;
		end else begin
			sfr_rdata        <= rdata_d;
			serial_done_flag <= flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin steering; no select pin exists here, slaves are chosen by gpio

	// the route that is not selected is parked low
	wire p1_sck_d  = route_p1 && sck_d;
	wire p1_mosi_d = route_p1 && shift_d[7];
	wire rf_sck_d  = route_rf && sck_d;
	wire rf_mosi_d = route_rf && shift_d[7];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			p1_sck_o      <= 1'b0;
			p1_mosi_o     <= 1'b0;
			p1_drive_oe_n <= 1'b1;
		end else begin
			p1_sck_o      <= p1_sck_d;
			p1_mosi_o     <= p1_mosi_d;
			p1_drive_oe_n <= !route_p1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			radio_sck  <= 1'b0;
			radio_mosi <= 1'b0;
		end else begin
			radio_sck  <= rf_sck_d;
			radio_mosi <= rf_mosi_d;
		end
	end
endmodule
